/* File: dwc_pkg.sv */
// Shared constants, types and lookup functions for the waveform/reset core
package dwc_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int BOOT_DELAY_US = 1000;
  localparam int BOOT_DELAY_CYCLES = BOOT_DELAY_US * 1000 / CLK_PERIOD_NS;
  localparam int NUM_CH = 2;
  localparam int CFG_WORDS = 5;
  localparam logic [4:0] SINE_LAST = 5'h17;
  // Register indices
  localparam logic [2:0] ADDR_FUNC0 = 3'h0;
  localparam logic [2:0] ADDR_FUNC1 = 3'h1;
  localparam logic [2:0] ADDR_COMMON = 3'h2;
  localparam logic [2:0] ADDR_VOUT0 = 3'h3;
  localparam logic [2:0] ADDR_VOUT1 = 3'h4;
  localparam logic [2:0] ADDR_TRIGGER = 3'h5;
  // Field positions
  localparam int FUNC_WAVE_LSB = 0;
  localparam int FUNC_SLEW_LSB = 4;
  localparam int FUNC_PHASE_LSB = 8;
  localparam int COM_LOCK_BIT = 0;
  localparam int COM_PD_LSB = 1;
  localparam int COM_PD_STRIDE = 3;
  localparam int COM_REF_BIT = 7;
  localparam int COM_GPIO_LSB = 8;
  localparam int VOUT_GAIN_LSB = 0;
  localparam int VOUT_CURR_BIT = 3;
  localparam int TRG_RESET_LSB = 0;
  localparam int TRG_UNLOCK_LSB = 4;
  localparam int TRG_PROG_BIT = 8;
  // Reset values
  localparam logic [15:0] DEF_FUNC = 16'h0000;
  localparam logic [15:0] DEF_COMMON = 16'h007e;
  localparam logic [15:0] DEF_VOUT = 16'h0000;
  // Codes
  localparam logic [2:0] WAVE_TRIANGLE = 3'h0;
  localparam logic [2:0] WAVE_SAW = 3'h1;
  localparam logic [2:0] WAVE_INV_SAW = 3'h2;
  localparam logic [2:0] WAVE_SINE = 3'h4;
  localparam logic [3:0] KEY_RESET = 4'ha;
  localparam logic [3:0] KEY_UNLOCK = 4'h5;
  localparam logic [1:0] GPIO_FN_RESET = 2'h1;
  localparam logic [1:0] GPIO_FN_SDO = 2'h2;
  localparam logic [1:0] PD_UP = 2'h0;
  localparam logic [1:0] PD_10K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_HIZ = 2'h3;
  localparam logic [11:0] SINE_MID = 12'h800;
  // Nonvolatile store layout
  localparam logic [3:0] NVM_USER_CRC = 4'h5;
  localparam logic [3:0] NVM_INT_CRC = 4'h8;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  typedef enum logic [3:0] {
    ST_READ = 4'h1,
    ST_DELAY = 4'h2,
    ST_READY = 4'h4,
    ST_PROG = 4'h8
  } dwc_boot_t;

  function automatic logic [15:0] dwc_crc16(input logic [15:0] crc,
                                            input logic [15:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ data[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [11:0] dwc_sine(input logic [4:0] idx);
    logic [11:0] v;
    v = SINE_MID;
    unique case (idx)
      5'h00, 5'h0c: v = 12'h800;
      5'h01, 5'h0b: v = 12'h9a8;
      5'h02, 5'h0a: v = 12'hb33;
      5'h03, 5'h09: v = 12'hc87;
      5'h04, 5'h08: v = 12'hd8b;
      5'h05, 5'h07: v = 12'he2f;
      5'h06: v = 12'he66;
      5'h0d, 5'h17: v = 12'h658;
      5'h0e, 5'h16: v = 12'h4cd;
      5'h0f, 5'h15: v = 12'h379;
      5'h10, 5'h14: v = 12'h275;
      5'h11, 5'h13: v = 12'h1d1;
      5'h12: v = 12'h19a;
      default: v = SINE_MID;
    endcase
    return v;
  endfunction

  function automatic logic [4:0] dwc_phase_start(input logic [1:0] sel);
    logic [4:0] s;
    unique case (sel)
      2'h0: s = 5'h00;
      2'h1: s = 5'h06;
      2'h2: s = 5'h08;
      2'h3: s = 5'h10;
    endcase
    return s;
  endfunction

  function automatic int dwc_step_ns(input logic [3:0] slew);
    int t;
    unique case (slew)
      4'h0: t = 4000;
      4'h1: t = 8000;
      4'h2: t = 12000;
      4'h3: t = 16000;
      4'h4: t = 20000;
      4'h5: t = 27000;
      4'h6: t = 40500;
      4'h7: t = 60750;
      4'h8: t = 91130;
      4'h9: t = 136690;
      4'ha: t = 239200;
      4'hb: t = 418610;
      4'hc: t = 732560;
      4'hd: t = 1281980;
      4'he: t = 2563960;
      4'hf: t = 5127920;
    endcase
    return t;
  endfunction
endpackage

/* File: dwc_chan_if.sv */
// Control and result signals between the core and one sine channel
`timescale 1ns/1ps
interface dwc_chan_if;
  logic [2:0] wave_sel;
  logic [3:0] slew;
  logic [1:0] phase;
  logic [11:0] code;
  logic sine_on;
  modport core (output wave_sel, output slew, output phase,
                input code, input sine_on);
  modport chan (input wave_sel, input slew, input phase,
                output code, output sine_on);
endinterface

/* File: dwc_sine_chan.sv */
// One channel sine sequencer stepping through the fixed table
`timescale 1ns/1ps
module dwc_sine_chan
  import dwc_pkg::*;
#(
  parameter int STEP_SCALE = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  dwc_chan_if.chan cif
);
  logic [4:0] idx_reg;
  logic [4:0] idx_next;
  logic [22:0] cnt_reg;
  logic [22:0] step_cycles;
  logic sine_sel;
  logic step_done;

  assign sine_sel = (cif.wave_sel == WAVE_SINE);
  always_comb begin
    step_cycles = 23'(dwc_step_ns(cif.slew) / CLK_PERIOD_NS / STEP_SCALE);
    if (step_cycles == 23'h0) begin
      step_cycles = 23'h1;
    end
  end
  assign step_done = (cnt_reg >= step_cycles - 23'h1);
  assign idx_next = (idx_reg == SINE_LAST) ? 5'h00 : idx_reg + 5'h01;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      idx_reg <= 5'h00;
      cnt_reg <= 23'h0;
      cif.sine_on <= 1'b0;
      cif.code <= SINE_MID;
    end else if (!sine_sel) begin
      idx_reg <= dwc_phase_start(cif.phase);
      cnt_reg <= 23'h0;
      cif.sine_on <= 1'b0;
    end else if (!cif.sine_on) begin
      idx_reg <= dwc_phase_start(cif.phase);
      cnt_reg <= 23'h0;
      cif.sine_on <= 1'b1;
      cif.code <= dwc_sine(dwc_phase_start(cif.phase));
    end else if (step_done) begin
      idx_reg <= idx_next;
      cnt_reg <= 23'h0;
      cif.code <= dwc_sine(idx_next);
    end else begin
      cnt_reg <= cnt_reg + 23'h1;
    end
  end

  a_sine_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cif.sine_on && sine_sel && step_done && idx_reg == SINE_LAST
    |=> idx_reg == 5'h00) else $error("sine index did not wrap");
  a_sine_code: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cif.sine_on |-> cif.code == dwc_sine(idx_reg))
    else $error("sine code off table");
  a_phase_start: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(cif.sine_on) |-> idx_reg == dwc_phase_start($past(cif.phase)))
    else $error("sine started at wrong phase");
  a_step_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cif.sine_on && sine_sel && !step_done && $stable(cif.slew)
    |=> $stable(idx_reg)) else $error("sine stepped early");
endmodule

/* File: dwc_core.sv */
// Waveform sequencing, boot reload, lock and power-down core
`timescale 1ns/1ps
// Functional notes
// - Sine advances one of 24 samples per slew time step.
// - Waveform select value 100 picks sine for that channel.
// - Sine codes come from a fixed 12-bit table around mid-scale.
// - Phase select starts sine at index 0, 6, 8 or 16.
// - Power-on loads registers from the store; access only after boot delay.
// - Trigger reset code 1010 starts a full boot like power-on.
// - Reset pin boots on the falling edge; rising edge does nothing.
// - Write-protect bit set rejects all register writes; the I2C trigger reset and the unlock key write still act.
// - Software reset over I2C still works while locked.
// - Unlock key 0101 in the trigger register bypasses write-protect.
// - Store programming writes a CRC-16; boot checks data against it.
// - Check alarms change only during boot, after the store is read.
// - User region check failure sets alarm and loads factory defaults.
// - Internal region check failure sets alarm and loads factory defaults.
// - Software reset or power cycle clears alarms and reloads the store.
// - Factory defaults leave both outputs and the reference off, Hi-Z.
// - Voltage power-down: 00 up, 01 10k, 10 100k, 11 Hi-Z.
// - Current-output channels always go Hi-Z when powered down.
// - Channel power state after boot comes from the store.
// - Host interface type fixed by first protocol until power cycle.
// - Four-wire SPI only when the pin is mapped as data out.
// - Select 000 triangle, 001 sawtooth, 010 inverse sawtooth.
module dwc_core
  import dwc_pkg::*;
#(
  parameter int BOOT_CYCLES = BOOT_DELAY_CYCLES,
  parameter int STEP_SCALE = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic host_wr_en,
  input wire logic [2:0] host_wr_addr,
  input wire logic [15:0] host_wr_data,
  input wire logic host_wr_i2c,
  input wire logic [2:0] host_rd_addr,
  output logic [15:0] host_rd_data,
  input wire logic if_i2c_seen,
  input wire logic if_spi_seen,
  input wire logic gpio_pin,
  output logic nvm_rd_en,
  output logic [3:0] nvm_rd_addr,
  input wire logic [15:0] nvm_rd_data,
  output logic nvm_wr_en,
  output logic [3:0] nvm_wr_addr,
  output logic [15:0] nvm_wr_data,
  output logic host_ready,
  output logic user_store_check_alarm,
  output logic factory_store_check_alarm,
  output logic write_locked,
  output logic if_type_valid,
  output logic if_type_spi,
  output logic spi_four_wire_en,
  output logic int_ref_en,
  output logic [11:0] dac_code_ch0,
  output logic [11:0] dac_code_ch1,
  output logic [1:0] sine_active,
  output logic [1:0] wave_known,
  output logic [1:0] out_state_ch0,
  output logic [1:0] out_state_ch1,
  output logic [2:0] output_gain_setting_ch0,
  output logic [2:0] output_gain_setting_ch1
);
  dwc_boot_t state_reg;
  logic [3:0] addr_reg;
  logic rd_pend_reg;
  logic rd_wait_reg;
  logic [15:0] crc_reg;
  logic [31:0] dly_reg;
  logic [15:0] cfg_reg [CFG_WORDS];
  logic bypass_reg;
  logic gpio_s1_reg;
  logic gpio_s2_reg;
  logic gpio_s3_reg;
  logic [1:0] pd_state [NUM_CH];

  logic rd_capture;
  logic chk_user_fail;
  logic chk_int_fail;
  logic locked;
  logic access_ok;
  logic trig_wr;
  logic soft_rst;
  logic prog_cmd;
  logic gpio_fall;
  logic boot_req;
  logic wr_ok;
  logic [1:0] gpio_fn;

  dwc_chan_if ch_if [NUM_CH] ();

  assign gpio_fn = cfg_reg[ADDR_COMMON][COM_GPIO_LSB +: 2];
  assign locked = cfg_reg[ADDR_COMMON][COM_LOCK_BIT] & ~bypass_reg;
  assign access_ok = host_wr_en && host_ready && (state_reg == ST_READY);
  assign trig_wr = access_ok && (host_wr_addr == ADDR_TRIGGER);
  assign soft_rst = trig_wr
    && (host_wr_data[TRG_RESET_LSB +: 4] == KEY_RESET)
    && (!locked || host_wr_i2c);
  assign prog_cmd = trig_wr && host_wr_data[TRG_PROG_BIT] && !locked;
  // Silent drop of locked or unmapped writes
  assign wr_ok = access_ok && (host_wr_addr < 3'(CFG_WORDS))
    && !locked;
  assign gpio_fall = (gpio_fn == GPIO_FN_RESET)
    && gpio_s3_reg && !gpio_s2_reg;
  assign boot_req = soft_rst || gpio_fall;
  assign rd_capture = (state_reg == ST_READ) && rd_pend_reg && rd_wait_reg;
  assign chk_user_fail = rd_capture && (addr_reg == NVM_USER_CRC)
    && (nvm_rd_data != crc_reg);
  assign chk_int_fail = rd_capture && (addr_reg == NVM_INT_CRC)
    && (nvm_rd_data != crc_reg);

  // Boot, reload and store programming sequence
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_READ;
      addr_reg <= 4'h0;
      rd_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      crc_reg <= CRC_INIT;
      dly_reg <= 32'h0;
      nvm_rd_en <= 1'b0;
      nvm_rd_addr <= 4'h0;
      nvm_wr_en <= 1'b0;
      nvm_wr_addr <= 4'h0;
      nvm_wr_data <= 16'h0000;
    end else begin
      nvm_rd_en <= 1'b0;
      nvm_wr_en <= 1'b0;
      rd_wait_reg <= nvm_rd_en;
      if (boot_req) begin
        state_reg <= ST_READ;
        addr_reg <= 4'h0;
        rd_pend_reg <= 1'b0;
        crc_reg <= CRC_INIT;
      end else begin
        unique case (state_reg)
          ST_READ: begin
            if (!rd_pend_reg) begin
              nvm_rd_en <= 1'b1;
              nvm_rd_addr <= addr_reg;
              rd_pend_reg <= 1'b1;
            end else if (rd_wait_reg) begin
              rd_pend_reg <= 1'b0;
              addr_reg <= addr_reg + 4'h1;
              if (addr_reg == NVM_USER_CRC || addr_reg == NVM_INT_CRC) begin
                crc_reg <= CRC_INIT;
              end else begin
                crc_reg <= dwc_crc16(crc_reg, nvm_rd_data);
              end
              if (addr_reg == NVM_INT_CRC) begin
                state_reg <= ST_DELAY;
                dly_reg <= 32'h0;
              end
            end
          end
          ST_DELAY: begin
            if (dly_reg >= 32'(BOOT_CYCLES - 1)) begin
              state_reg <= ST_READY;
            end else begin
              dly_reg <= dly_reg + 32'h1;
            end
          end
          ST_READY: begin
            if (prog_cmd) begin
              state_reg <= ST_PROG;
              addr_reg <= 4'h0;
              crc_reg <= CRC_INIT;
            end
          end
          ST_PROG: begin
            nvm_wr_en <= 1'b1;
            nvm_wr_addr <= addr_reg;
            addr_reg <= addr_reg + 4'h1;
            if (addr_reg == NVM_USER_CRC) begin
              nvm_wr_data <= crc_reg;
              state_reg <= ST_READY;
            end else begin
              nvm_wr_data <= cfg_reg[addr_reg[2:0]];
              crc_reg <= dwc_crc16(crc_reg, cfg_reg[addr_reg[2:0]]);
            end
          end
        endcase
      end
    end
  end

  // Register contents
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_reg[i] <= (i == int'(ADDR_COMMON)) ? DEF_COMMON
          : (i >= int'(ADDR_VOUT0)) ? DEF_VOUT : DEF_FUNC;
      end
    end else if (chk_user_fail || chk_int_fail) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_reg[i] <= (i == int'(ADDR_COMMON)) ? DEF_COMMON
          : (i >= int'(ADDR_VOUT0)) ? DEF_VOUT : DEF_FUNC;
      end
    end else if (rd_capture && addr_reg < 4'(CFG_WORDS)) begin
      cfg_reg[addr_reg[2:0]] <= nvm_rd_data;
    end else if (wr_ok) begin
      cfg_reg[host_wr_addr] <= host_wr_data;
    end
  end

  // Write-protect bypass
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bypass_reg <= 1'b0;
    end else if (boot_req) begin
      bypass_reg <= 1'b0;
    end else if (trig_wr
                 && host_wr_data[TRG_UNLOCK_LSB +: 4] == KEY_UNLOCK) begin
      bypass_reg <= 1'b1;
    end
  end

  // Store check alarms, touched only by the boot sequence
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      user_store_check_alarm <= 1'b0;
      factory_store_check_alarm <= 1'b0;
    end else begin
      if (boot_req) begin
        user_store_check_alarm <= 1'b0;
        factory_store_check_alarm <= 1'b0;
      end
      if (chk_user_fail) begin
        user_store_check_alarm <= 1'b1;
      end
      if (chk_int_fail) begin
        factory_store_check_alarm <= 1'b1;
      end
    end
  end

  // Host interface type, held until the next power-on reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      if_type_valid <= 1'b0;
      if_type_spi <= 1'b0;
    end else if (!if_type_valid && (if_i2c_seen || if_spi_seen)) begin
      if_type_valid <= 1'b1;
      if_type_spi <= !if_i2c_seen;
    end
  end

  // Reset pin synchroniser
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gpio_s1_reg <= 1'b1;
      gpio_s2_reg <= 1'b1;
      gpio_s3_reg <= 1'b1;
    end else begin
      gpio_s1_reg <= gpio_pin;
      gpio_s2_reg <= gpio_s1_reg;
      gpio_s3_reg <= gpio_s2_reg;
    end
  end

  // Power-down decode per channel
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (cfg_reg[int'(ADDR_VOUT0) + c][VOUT_CURR_BIT]) begin
        pd_state[c] =
          cfg_reg[ADDR_COMMON][COM_PD_LSB + COM_PD_STRIDE * c + 2]
          ? PD_HIZ : PD_UP;
      end else begin
        pd_state[c] =
          cfg_reg[ADDR_COMMON][COM_PD_LSB + COM_PD_STRIDE * c +: 2];
      end
    end
  end

  // Registered status and control outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      host_ready <= 1'b0;
      write_locked <= 1'b0;
      spi_four_wire_en <= 1'b0;
      int_ref_en <= 1'b0;
      out_state_ch0 <= PD_HIZ;
      out_state_ch1 <= PD_HIZ;
      output_gain_setting_ch0 <= 3'h0;
      output_gain_setting_ch1 <= 3'h0;
      host_rd_data <= 16'h0000;
    end else begin
      host_ready <= (state_reg == ST_READY) && !boot_req;
      write_locked <= locked;
      spi_four_wire_en <= (gpio_fn == GPIO_FN_SDO);
      int_ref_en <= cfg_reg[ADDR_COMMON][COM_REF_BIT];
      out_state_ch0 <= pd_state[0];
      out_state_ch1 <= pd_state[1];
      output_gain_setting_ch0 <= cfg_reg[ADDR_VOUT0][VOUT_GAIN_LSB +: 3];
      output_gain_setting_ch1 <= cfg_reg[ADDR_VOUT1][VOUT_GAIN_LSB +: 3];
      host_rd_data <= (host_rd_addr < 3'(CFG_WORDS))
        ? cfg_reg[host_rd_addr] : 16'h0000;
    end
  end

  // Sine channels
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign ch_if[c].wave_sel = cfg_reg[c][FUNC_WAVE_LSB +: 3];
    assign ch_if[c].slew = cfg_reg[c][FUNC_SLEW_LSB +: 4];
    assign ch_if[c].phase = cfg_reg[c][FUNC_PHASE_LSB +: 2];
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        wave_known[c] <= 1'b0;
      end else begin
        unique case (cfg_reg[c][FUNC_WAVE_LSB +: 3])
          WAVE_TRIANGLE, WAVE_SAW, WAVE_INV_SAW,
          WAVE_SINE: wave_known[c] <= 1'b1;
          default: wave_known[c] <= 1'b0;
        endcase
      end
    end
    dwc_sine_chan #(.STEP_SCALE(STEP_SCALE)) u_chan (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .cif(ch_if[c])
    );
    assign sine_active[c] = ch_if[c].sine_on;
  end
  assign dac_code_ch0 = ch_if[0].code;
  assign dac_code_ch1 = ch_if[1].code;

  a_lock_reject: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wr_ok == 1'b0 && access_ok && locked && host_wr_addr == ADDR_COMMON
    |=> $stable(cfg_reg[ADDR_COMMON]))
    else $error("locked write changed a register");
  a_unlock_key: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trig_wr && !boot_req && host_wr_data[7:4] == KEY_UNLOCK
    |=> !locked) else $error("unlock key ignored");
  a_soft_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trig_wr && host_wr_i2c && host_wr_data[3:0] == KEY_RESET
    |=> state_reg == ST_READ && !user_store_check_alarm && !host_ready)
    else $error("software reset not taken");
  a_alarm_boot: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(user_store_check_alarm) || $rose(factory_store_check_alarm)
    |-> $past(state_reg) == ST_READ)
    else $error("alarm set outside boot");
  a_fail_default: assert property (@(posedge ref_clk) disable iff (!reset_n)
    chk_user_fail && !boot_req |=> cfg_reg[ADDR_COMMON] == DEF_COMMON
    && user_store_check_alarm) else $error("defaults not loaded");
  a_current_hiz: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfg_reg[ADDR_VOUT0][VOUT_CURR_BIT] && cfg_reg[ADDR_COMMON][3]
    |=> out_state_ch0 == PD_HIZ)
    else $error("current mode not Hi-Z");
  a_type_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    if_type_valid |=> if_type_valid && $stable(if_type_spi))
    else $error("interface type changed");
  a_pin_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    gpio_fn == GPIO_FN_RESET && gpio_s3_reg && !gpio_s2_reg
    |=> state_reg == ST_READ) else $error("reset pin ignored");
  a_sdo_map: assert property (@(posedge ref_clk) disable iff (!reset_n)
    spi_four_wire_en |-> $past(gpio_fn) == GPIO_FN_SDO)
    else $error("four-wire without pin map");
endmodule

/* File: dwc_store_model.sv */
// Registered nonvolatile store model with optional word corruption
`timescale 1ns/1ps
module dwc_store_model (
  input wire logic ref_clk,
  input wire logic rd_en,
  input wire logic [3:0] rd_addr,
  output logic [15:0] rd_data,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] corrupt
);
  logic [15:0] mem [16];
  logic [15:0] flip;
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction
  initial begin
    mem = '{default: 16'h0000};
    mem[0] = 16'h0004;
    mem[1] = 16'h0104;
    mem[2] = 16'h0022;
    mem[6] = 16'h1234;
    mem[7] = 16'h5678;
    mem[5] = 16'hffff;
    for (int i = 0; i < 5; i++) mem[5] = crc(mem[5], mem[i]);
    mem[8] = crc(crc(16'hffff, mem[6]), mem[7]);
    rd_data = 16'h0000;
  end
  assign flip = {15'h0, (corrupt[0] && rd_addr == 4'h0) ||
                        (corrupt[1] && rd_addr == 4'h6)};
  // Data only valid the cycle after a read; otherwise it toggles
  always @(posedge ref_clk) begin
    rd_data <= rd_en ? (mem[rd_addr] ^ flip) : ~rd_data;
    if (wr_en) mem[wr_addr] <= wr_data;
  end
endmodule

/* File: dwc_core_tb.sv */
// Self-checking testbench for the waveform and reset core
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITF(c) begin for (int w = 0; w < 300 && !(c); w++) tick(); \
  if (!(c)) begin errors++; conclude(); end end
module dwc_core_tb;
  import dwc_pkg::*;
  logic ref_clk = 0, reset_n = 0, host_wr_en = 0, host_wr_i2c = 0;
  logic [2:0] host_wr_addr = 0, host_rd_addr = 0;
  logic [15:0] host_wr_data = 0, host_rd_data, nvm_rd_data, nvm_wr_data, e;
  logic if_i2c_seen = 0, if_spi_seen = 0, gpio_pin = 1, nvm_rd_en, nvm_wr_en;
  logic [3:0] nvm_rd_addr, nvm_wr_addr;
  logic host_ready, user_store_check_alarm, factory_store_check_alarm;
  logic write_locked, if_type_valid, if_type_spi, spi_four_wire_en, int_ref_en;
  logic [11:0] dac_code_ch0, dac_code_ch1;
  logic [1:0] sine_active, wave_known, out_state_ch0, out_state_ch1;
  logic [1:0] corrupt = 0;
  logic [2:0] output_gain_setting_ch0, output_gain_setting_ch1, g;
  logic rd_v = 0, v1 = 0;
  logic [15:0] q[$];
  int errors = 0, num_checks = 0;
  dwc_core #(.BOOT_CYCLES(20), .STEP_SCALE(1000)) dut (.*);
  dwc_store_model store (.ref_clk(ref_clk), .rd_en(nvm_rd_en),
    .rd_addr(nvm_rd_addr), .rd_data(nvm_rd_data), .wr_en(nvm_wr_en),
    .wr_addr(nvm_wr_addr), .wr_data(nvm_wr_data), .corrupt(corrupt));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic tick;
    @(posedge ref_clk) #1;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d,
                    input logic i2c = 0);
    host_wr_addr = a;
    host_wr_data = d;
    host_wr_i2c = i2c;
    host_wr_en = 1;
    tick();
    host_wr_en = 0;
    tick();
    tick();
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] x);
    host_rd_addr = a;
    q.push_back(x);
    rd_v = 1;
    tick();
    rd_v = 0;
    tick();
  endtask
  // Read results are matched against the oldest pending note
  always @(posedge ref_clk) begin
    if (v1) begin
      e = q.pop_front();
      `CHK(host_rd_data, e)
    end
    v1 = rd_v;
  end
  task automatic sreset(input logic i2c);
    wr(3'h5, 16'h000a, i2c);
    `CHK(host_ready, !i2c)
    `WAITF(host_ready === 1'b1)
  endtask
  function automatic logic [11:0] sv(input int i);
    logic [11:0] h[7];
    int j;
    h = '{12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f, 12'he66};
    j = i % 12;
    if (j > 6) j = 12 - j;
    return (i % 24 < 12) ? h[j] : 12'h000 - h[j];
  endfunction
  task automatic sine(input logic [1:0] ph, input logic [3:0] sl, input int n);
    int s;
    s = ph == 0 ? 0 : ph == 1 ? 6 : ph == 2 ? 8 : 16;
    wr(3'h0, 16'h0000);
    wr(3'h0, {6'h0, ph, sl, 4'h4});
    `WAITF(dac_code_ch0 === sv(s + 1))
    for (int i = 1; i < 27; i++) begin
      `CHK(dac_code_ch0, sv(s + i))
      repeat (n) tick();
    end
  endtask
  initial begin
    void'($urandom(23216));
    repeat (16) tick();
    reset_n = 1;
    `WAITF(host_ready === 1'b1)
    rd(3'h1, 16'h0104);
    rd(3'h6, 16'h0000);
    `CHK(out_state_ch0, PD_10K)
    `CHK(out_state_ch1, PD_100K)
    `CHK(sine_active, 2'b11)
    `WAITF(dac_code_ch1 === 12'h19a)
    tick();
    `CHK(dac_code_ch1, 12'h1d1)
    for (int p = 0; p < 4; p++) sine(p, 4'h0, 1);
    sine(2'h1, 4'h6, 5);
    for (int w = 0; w < 8; w++) begin
      wr(3'h0, w);
      `CHK(wave_known[0], w inside {0, 1, 2, 4})
    end
    for (int p = 0; p < 4; p++) begin
      wr(3'h2, (p << 4) | (p << 1) | (p << 7));
      `CHK(out_state_ch0, p[1:0])
      `CHK(out_state_ch1, p[1:0])
    end
    wr(3'h3, 16'h000d);
    wr(3'h2, 16'h000a);
    `CHK(out_state_ch0, PD_HIZ)
    `CHK(output_gain_setting_ch0, 3'h5)
    g = $urandom;
    wr(3'h4, g);
    `CHK(output_gain_setting_ch1, g)
    wr(3'h2, 16'h0001);
    `CHK(write_locked, 1'b1)
    wr(3'h1, 16'h00ff);
    wr(3'h2, 16'h0000);
    `CHK(write_locked, 1'b1)
    rd(3'h1, 16'h0104);
    sreset(0);
    wr(3'h5, 16'h0050);
    `CHK(write_locked, 1'b0)
    wr(3'h1, 16'h0004);
    wr(3'h2, 16'h0122);
    wr(3'h5, 16'h0100);
    repeat (10) tick();
    gpio_pin = 0;
    `WAITF(host_ready === 1'b0)
    `WAITF(host_ready === 1'b1)
    rd(3'h1, 16'h0004);
    `CHK(user_store_check_alarm, 1'b0)
    gpio_pin = 1;
    repeat (10) tick();
    `CHK(host_ready, 1'b1)
    wr(3'h2, 16'h0223);
    `CHK(spi_four_wire_en, 1'b1)
    sreset(1);
    corrupt = 2'h1;
    sreset(1);
    `CHK(user_store_check_alarm, 1'b1)
    rd(3'h2, DEF_COMMON);
    `CHK(out_state_ch1, PD_HIZ)
    `CHK(int_ref_en, 1'b0)
    wr(3'h0, 16'h0001);
    rd(3'h0, 16'h0001);
    corrupt = 2'h2;
    sreset(1);
    `CHK(factory_store_check_alarm, 1'b1)
    corrupt = 2'h0;
    sreset(1);
    `CHK({user_store_check_alarm, factory_store_check_alarm}, 2'b00)
    if_spi_seen = 1;
    tick();
    if_spi_seen = 0;
    if_i2c_seen = 1;
    tick();
    if_i2c_seen = 0;
    sreset(1);
    `CHK({if_type_valid, if_type_spi}, 2'b11)
    conclude();
  end
endmodule
